// [src/cssq_top.sv]
/*
  Reset sequencer of a dual serial converter-link subsystem, with the
  fabric status word and control word seen by the soft processor.
  Assumes a simple word bus from the subsystem bridge (address, read and
  write strobes, one-cycle read answer) on mclk_in, and qualifiers and
  fabric status arriving asynchronously.
*/
`timescale 1ns/1ps
`include "cssq_regs.svh"

// Functional notes
// - Hardware reset always runs the built-in release order, no software.
// - Software reset runs built-in order or lets software release outputs itself.
// - PHY reset held until core PLL lock qualifier is true.
// - TX config, link, frame releases wait for TX ready, in that order.
// - RX config, link, frame releases wait for RX ready, after TX chain.
// - PHY reset output feeds both link cores' PHY via reset controller.
// - Config resets clear the link cores' register banks, apart from datapath.
// - Link resets cover link core base logic and transport link side.
// - Frame resets cover transport frame side and pattern generators, checkers.
// - Registers decode in a 256-byte window on the bridge port.
// - One read-only 32-bit status word and one 32-bit control word.
// - Status bit 0 PLL locked, bit 1 link 0 TX ready, bit 2 RX ready.
// - Status bit 3 is link 0 checker data error.
// - Bits 4 to 31 repeat the triplet per further link, else zero.
// - Control bit 0 enables RX serial loopback on both cores; rest reserved.
module cssq_top #(
  parameter int LINKS = 2   // Link instances present, 1 to 10
) (
  input  wire logic             mclk_in,              // 200 MHz system clock
  input  wire logic             resetn_in,            // Synchronous reset, low
  input  wire logic             hardware_reset_button_n_in, // Push button, low pressed
  input  wire logic             pll_locked_qualifier_in,    // Core PLL locked
  input  wire logic             tx_ready_qualifier_in,      // TX transceiver ready
  input  wire logic             rx_ready_qualifier_in,      // RX transceiver ready
  input  wire logic [LINKS-1:0] link_tx_ready_in,     // Per link TX ready
  input  wire logic [LINKS-1:0] link_rx_ready_in,     // Per link RX ready
  input  wire logic [LINKS-1:0] link_chk_err_in,      // Per link checker error
  input  wire logic [31:0]      bus_addr_in,          // Bridge byte address
  input  wire logic             bus_write_in,         // Write strobe
  input  wire logic             bus_read_in,          // Read strobe
  input  wire logic [31:0]      bus_wdata_in,         // Write data
  output logic      [31:0]      bus_rdata_out,        // Read data
  output logic                  bus_rdvalid_out,      // Read answer pulse
  output logic                  core_pll_reset_out,   // Core PLL reset, high
  output logic                  phy_reset_out,        // PHY reset, high
  output logic                  tx_cfg_reset_out,     // TX register bank reset
  output logic                  tx_link_reset_out,    // TX link reset
  output logic                  tx_frame_reset_out,   // TX frame reset
  output logic                  rx_cfg_reset_out,     // RX register bank reset
  output logic                  rx_link_reset_out,    // RX link reset
  output logic                  rx_frame_reset_out,   // RX frame reset
  output logic      [31:0]      fabric_control_out,   // Control word to fabric
  output logic                  rx_loopback_en_out    // RX serial loopback enable
);

  localparam int STAT_W = `CSSQ_FST_LINK_LSB + `CSSQ_FST_PER_LINK * LINKS;
  localparam logic [`CSSQ_CNT_W-1:0] STEP_CYC =
    (`CSSQ_STEP_CYC < 1) ? `CSSQ_CNT_W'(1) : `CSSQ_CNT_W'(`CSSQ_STEP_CYC);

  // Word offset inside the window, or no hit
  function automatic logic win_hit(input logic [31:0] addr);
    win_hit = ((addr & `CSSQ_WIN_MASK) == `CSSQ_WIN_BASE);
  endfunction

  function automatic logic [7:0] win_ofs(input logic [31:0] addr);
    win_ofs = 8'(addr & `CSSQ_OFS_MASK);
  endfunction

  // Synchronised pins
  logic                button_n_s;
  logic [2:0]          qual_s;
  logic [STAT_W-1:0]   stat_raw;
  logic [STAT_W-1:0]   stat_s;
  logic                pll_ok;
  logic                tx_ok;
  logic                rx_ok;

  cssq_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_sync_button (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  (hardware_reset_button_n_in),
    .sync_out  (button_n_s)
  );

  cssq_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h0)
  ) u_sync_qual (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  ({rx_ready_qualifier_in, tx_ready_qualifier_in,
                 pll_locked_qualifier_in}),
    .sync_out  (qual_s)
  );

  assign stat_raw[`CSSQ_FST_PLL] = pll_locked_qualifier_in;

  genvar gi;
  generate
    for (gi = 0; gi < LINKS; gi++) begin : g_link
      assign stat_raw[`CSSQ_FST_LINK_LSB + `CSSQ_FST_PER_LINK * gi]     = link_tx_ready_in[gi];
      assign stat_raw[`CSSQ_FST_LINK_LSB + `CSSQ_FST_PER_LINK * gi + 1] = link_rx_ready_in[gi];
      assign stat_raw[`CSSQ_FST_LINK_LSB + `CSSQ_FST_PER_LINK * gi + 2] = link_chk_err_in[gi];
    end
  endgenerate

  cssq_sync #(
    .WIDTH     (STAT_W),
    .RESET_VAL ('0)
  ) u_sync_stat (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  (stat_raw),
    .sync_out  (stat_s)
  );

  assign pll_ok = qual_s[0];
  assign tx_ok  = qual_s[1];
  assign rx_ok  = qual_s[2];

  // Register bus decode
  logic       hit;
  logic [7:0] ofs;
  logic       wr_ctrl;
  logic       wr_manual;
  logic       wr_fct;

  assign hit       = win_hit(bus_addr_in);
  assign ofs       = win_ofs(bus_addr_in);
  assign wr_ctrl   = bus_write_in && hit && (ofs == `CSSQ_OFS_SEQ_CTRL);
  assign wr_manual = bus_write_in && hit && (ofs == `CSSQ_OFS_MANUAL);
  assign wr_fct    = bus_write_in && hit && (ofs == `CSSQ_OFS_FAB_CTRL);

  // Software reset request and override choice
  logic [1:0] ctrl_q;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ctrl_q <= `CSSQ_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= {bus_wdata_in[`CSSQ_CTRL_OVRD], bus_wdata_in[`CSSQ_CTRL_SWRST]};
    end
  end

  logic [`CSSQ_RST_W-1:0] manual_q;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      manual_q <= `CSSQ_RST_ALL;
    end else if (wr_manual) begin
      manual_q <= bus_wdata_in[`CSSQ_RST_W-1:0];
    end
  end

  // Only loopback bit stored; reserved bits read zero
  logic fct_q;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      fct_q <= `CSSQ_RST_FCT;
    end else if (wr_fct) begin
      fct_q <= bus_wdata_in[`CSSQ_FCT_LOOPBACK];
    end
  end

  // Global reset sources
  logic hw_rst;
  logic sw_rst;
  logic hw_cause_q;

  assign hw_rst = !button_n_s;
  assign sw_rst = ctrl_q[`CSSQ_CTRL_SWRST];

  // Remember hardware origin so release ignores override
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      hw_cause_q <= 1'b1;
    end else if (hw_rst) begin
      hw_cause_q <= 1'b1;
    end else if (sw_rst) begin
      hw_cause_q <= 1'b0;
    end
  end

  // Release state machine
  cssq_pkg::cssq_state_t  state_q;
  cssq_pkg::cssq_state_t  state_d;
  logic [`CSSQ_CNT_W-1:0] dwell_q;
  logic                   dwell_done;

  assign dwell_done = (dwell_q == '0);

  always_comb begin
    state_d = state_q;
    case (state_q)
      cssq_pkg::CSSQ_ST_HOLD: begin
        if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_PLL;
        end
      end
      cssq_pkg::CSSQ_ST_PLL: begin
        if (dwell_done && pll_ok) begin
          state_d = cssq_pkg::CSSQ_ST_PHY;
        end
      end
      cssq_pkg::CSSQ_ST_PHY: begin
        if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_TXWAIT;
        end
      end
      // TX chain waits for TX ready
      cssq_pkg::CSSQ_ST_TXWAIT: begin
        if (dwell_done && tx_ok) begin
          state_d = cssq_pkg::CSSQ_ST_TXCFG;
        end
      end
      cssq_pkg::CSSQ_ST_TXCFG: begin
        if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_TXLINK;
        end
      end
      cssq_pkg::CSSQ_ST_TXLINK: begin
        if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_RXWAIT;
        end
      end
      // RX chain after TX, waits for RX ready
      cssq_pkg::CSSQ_ST_RXWAIT: begin
        if (dwell_done && rx_ok) begin
          state_d = cssq_pkg::CSSQ_ST_RXCFG;
        end
      end
      cssq_pkg::CSSQ_ST_RXCFG: begin
        if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_RXLINK;
        end
      end
      cssq_pkg::CSSQ_ST_RXLINK: begin
        if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_DONE;
        end
      end
      cssq_pkg::CSSQ_ST_DONE: begin
        state_d = cssq_pkg::CSSQ_ST_DONE;
      end
      cssq_pkg::CSSQ_ST_MANUAL: begin
        state_d = cssq_pkg::CSSQ_ST_MANUAL;
      end
      // Software release: override or built-in order
      cssq_pkg::CSSQ_ST_SWHOLD: begin
        if (ctrl_q[`CSSQ_CTRL_OVRD]) begin
          state_d = cssq_pkg::CSSQ_ST_MANUAL;
        end else if (dwell_done) begin
          state_d = cssq_pkg::CSSQ_ST_PLL;
        end
      end
      default: begin
        state_d = cssq_pkg::CSSQ_ST_HOLD;
      end
    endcase
    if (hw_rst || sw_rst) begin
      state_d = cssq_pkg::CSSQ_ST_HOLD;
    end else if (state_q == cssq_pkg::CSSQ_ST_HOLD && !hw_cause_q && dwell_q == STEP_CYC) begin
      state_d = cssq_pkg::CSSQ_ST_SWHOLD;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_q <= cssq_pkg::CSSQ_ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      dwell_q <= STEP_CYC;
    end else if (state_d != state_q || hw_rst || sw_rst) begin
      dwell_q <= STEP_CYC;
    end else if (!dwell_done) begin
      dwell_q <= dwell_q - `CSSQ_CNT_W'(1);
    end
  end

  // Reset pattern per state, bit set means asserted
  logic [`CSSQ_RST_W-1:0] rst_d;

  always_comb begin
    rst_d = `CSSQ_RST_ALL;
    case (state_d)
      cssq_pkg::CSSQ_ST_HOLD:   rst_d = `CSSQ_RST_ALL;
      cssq_pkg::CSSQ_ST_SWHOLD: rst_d = `CSSQ_RST_ALL;
      cssq_pkg::CSSQ_ST_PLL:    rst_d = 8'hfe;
      cssq_pkg::CSSQ_ST_PHY:    rst_d = 8'hfc;
      cssq_pkg::CSSQ_ST_TXWAIT: rst_d = 8'hfc;
      cssq_pkg::CSSQ_ST_TXCFG:  rst_d = 8'hf8;
      cssq_pkg::CSSQ_ST_TXLINK: rst_d = 8'hf0;
      cssq_pkg::CSSQ_ST_RXWAIT: rst_d = 8'he0;
      cssq_pkg::CSSQ_ST_RXCFG:  rst_d = 8'hc0;
      cssq_pkg::CSSQ_ST_RXLINK: rst_d = 8'h80;
      cssq_pkg::CSSQ_ST_DONE:   rst_d = 8'h00;
      cssq_pkg::CSSQ_ST_MANUAL: rst_d = manual_q;
      default:                  rst_d = `CSSQ_RST_ALL;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      core_pll_reset_out <= 1'b1;
      phy_reset_out      <= 1'b1;
      tx_cfg_reset_out   <= 1'b1;
      tx_link_reset_out  <= 1'b1;
      tx_frame_reset_out <= 1'b1;
      rx_cfg_reset_out   <= 1'b1;
      rx_link_reset_out  <= 1'b1;
      rx_frame_reset_out <= 1'b1;
    end else begin
      core_pll_reset_out <= rst_d[`CSSQ_RST_PLL];
      phy_reset_out      <= rst_d[`CSSQ_RST_PHY];
      tx_cfg_reset_out   <= rst_d[`CSSQ_RST_TXCFG];
      tx_link_reset_out  <= rst_d[`CSSQ_RST_TXLINK];
      tx_frame_reset_out <= rst_d[`CSSQ_RST_TXFRAME];
      rx_cfg_reset_out   <= rst_d[`CSSQ_RST_RXCFG];
      rx_link_reset_out  <= rst_d[`CSSQ_RST_RXLINK];
      rx_frame_reset_out <= rst_d[`CSSQ_RST_RXFRAME];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rx_loopback_en_out <= 1'b0;
      fabric_control_out <= `CSSQ_ZERO_WORD;
    end else begin
      rx_loopback_en_out <= fct_q;
      fabric_control_out <= {31'h0000_0000, fct_q};
    end
  end

  // Window decode, read answer one cycle later
  logic [31:0] rd_word;
  logic [7:0]  cur_rst;

  assign cur_rst = {rx_frame_reset_out, rx_link_reset_out, rx_cfg_reset_out,
                    tx_frame_reset_out, tx_link_reset_out, tx_cfg_reset_out,
                    phy_reset_out, core_pll_reset_out};

  always_comb begin
    rd_word = `CSSQ_ZERO_WORD;
    if (hit) begin
      case (ofs)
        `CSSQ_OFS_SEQ_CTRL: rd_word[1:0] = ctrl_q;
        `CSSQ_OFS_MANUAL:   rd_word[`CSSQ_RST_W-1:0] = manual_q;
        `CSSQ_OFS_SEQ_STAT: begin
          rd_word[`CSSQ_RST_W-1:0] = cur_rst;
          rd_word[`CSSQ_STAT_STATE_LSB +: 12] = state_q;
          rd_word[`CSSQ_STAT_MANUAL]  = (state_q == cssq_pkg::CSSQ_ST_MANUAL);
          rd_word[`CSSQ_STAT_HWCAUSE] = hw_cause_q;
        end
        `CSSQ_OFS_FAB_STAT: rd_word[STAT_W-1:0] = stat_s;
        `CSSQ_OFS_FAB_CTRL: rd_word[`CSSQ_FCT_LOOPBACK] = fct_q;
        default:            rd_word = `CSSQ_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      bus_rdata_out   <= `CSSQ_ZERO_WORD;
      bus_rdvalid_out <= 1'b0;
    end else begin
      bus_rdvalid_out <= bus_read_in;
      bus_rdata_out   <= bus_read_in ? rd_word : `CSSQ_ZERO_WORD;
    end
  end

endmodule

// [pkg/cssq_regs.svh]
/*
  Register map, field positions, reset values and timing counts of the
  converter subsystem reset sequencer.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CSSQ_REGS_SVH
`define CSSQ_REGS_SVH

// Decode window on the subsystem bridge port
`define CSSQ_WIN_BASE      32'h0000_e000
`define CSSQ_WIN_MASK      32'hffff_ff00
`define CSSQ_OFS_MASK      32'h0000_00ff

// Word offsets inside the window
`define CSSQ_OFS_SEQ_CTRL  8'h00
`define CSSQ_OFS_MANUAL    8'h04
`define CSSQ_OFS_SEQ_STAT  8'h08
`define CSSQ_OFS_FAB_STAT  8'h10
`define CSSQ_OFS_FAB_CTRL  8'h14

// Sequencer control fields
`define CSSQ_CTRL_SWRST    0
`define CSSQ_CTRL_OVRD     1

// Manual reset output bit order, also used in the sequencer status word
`define CSSQ_RST_PLL       0
`define CSSQ_RST_PHY       1
`define CSSQ_RST_TXCFG     2
`define CSSQ_RST_TXLINK    3
`define CSSQ_RST_TXFRAME   4
`define CSSQ_RST_RXCFG     5
`define CSSQ_RST_RXLINK    6
`define CSSQ_RST_RXFRAME   7
`define CSSQ_RST_ALL       8'hff
`define CSSQ_RST_W         8

// Sequencer status fields
`define CSSQ_STAT_STATE_LSB 8
`define CSSQ_STAT_MANUAL    24
`define CSSQ_STAT_HWCAUSE   25

// Fabric status and control word layout
`define CSSQ_FST_PLL       0
`define CSSQ_FST_LINK_LSB  1
`define CSSQ_FST_PER_LINK  3
`define CSSQ_FCT_LOOPBACK  0

// Reset values
`define CSSQ_RST_CTRL      2'h0
`define CSSQ_RST_FCT       1'h0
`define CSSQ_ZERO_WORD     32'h0000_0000

// Dwell between two releases, in ns, and clock period in ps
`define CSSQ_STEP_NS       40
`define CSSQ_CLK_PS        5000
`define CSSQ_STEP_CYC      ((`CSSQ_STEP_NS * 1000) / `CSSQ_CLK_PS)
`define CSSQ_CNT_W         8

`endif

// [pkg/cssq_pkg.sv]
/*
  Types of the converter subsystem reset sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cssq_pkg;

  // Release order, one-hot
  typedef enum logic [11:0] {
    CSSQ_ST_HOLD    = 12'h001,
    CSSQ_ST_PLL     = 12'h002,
    CSSQ_ST_PHY     = 12'h004,
    CSSQ_ST_TXWAIT  = 12'h008,
    CSSQ_ST_TXCFG   = 12'h010,
    CSSQ_ST_TXLINK  = 12'h020,
    CSSQ_ST_RXWAIT  = 12'h040,
    CSSQ_ST_RXCFG   = 12'h080,
    CSSQ_ST_RXLINK  = 12'h100,
    CSSQ_ST_DONE    = 12'h200,
    CSSQ_ST_MANUAL  = 12'h400,
    CSSQ_ST_SWHOLD  = 12'h800
  } cssq_state_t;

endpackage

// [src/cssq_sync.sv]
/*
  Two-flop level synchroniser, vector wide.
  Assumes each bit is an independent quasi-static level.
*/
`timescale 1ns/1ps
module cssq_sync #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk_in,   // System clock
  input  wire logic             resetn_in, // Synchronous reset, low
  input  wire logic [WIDTH-1:0] async_in,  // Level from another domain
  output logic      [WIDTH-1:0] sync_out   // Level in mclk domain
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// [testbench/cssq_top_monitor.sv]
/*
  Port checker of cssq_top, bound into every instance.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module cssq_top_monitor (
  input wire logic        mclk_in,                    // Clock
  input wire logic        resetn_in,                  // Reset, low
  input wire logic        hardware_reset_button_n_in, // Button, low
  input wire logic        pll_locked_qualifier_in,    // PLL locked
  input wire logic        tx_ready_qualifier_in,      // TX ready
  input wire logic        rx_ready_qualifier_in,      // RX ready
  input wire logic [31:0] bus_addr_in,                // Address
  input wire logic        bus_write_in,               // Write
  input wire logic        bus_read_in,                // Read
  input wire logic [31:0] bus_wdata_in,               // Write data
  input wire logic [31:0] bus_rdata_out,              // Read data
  input wire logic        bus_rdvalid_out,            // Read answer
  input wire logic        core_pll_reset_out,         // Reset 0
  input wire logic        phy_reset_out,              // Reset 1
  input wire logic        tx_cfg_reset_out,           // Reset 2
  input wire logic        tx_link_reset_out,          // Reset 3
  input wire logic        tx_frame_reset_out,         // Reset 4
  input wire logic        rx_cfg_reset_out,           // Reset 5
  input wire logic        rx_link_reset_out,          // Reset 6
  input wire logic        rx_frame_reset_out,         // Reset 7
  input wire logic [31:0] fabric_control_out,         // Control word
  input wire logic        rx_loopback_en_out          // Loopback
);
  logic [7:0] rst_v;
  assign rst_v = {rx_frame_reset_out, rx_link_reset_out, rx_cfg_reset_out, tx_frame_reset_out,
                  tx_link_reset_out, tx_cfg_reset_out, phy_reset_out, core_pll_reset_out};
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence button_held;
    !hardware_reset_button_n_in [*6];
  endsequence
  sequence sw_reset_write;
    bus_write_in && bus_addr_in == 32'h0000_e000 && bus_wdata_in[0];
  endsequence
  reset_all_a: assert property (disable iff (1'b0) !resetn_in |=> rst_v == 8'hff &&
    fabric_control_out == 32'h0000_0000 && !bus_rdvalid_out) else $error("reset state wrong");
  button_all_a: assert property (button_held |-> rst_v == 8'hff)
    else $error("button did not assert resets");
  sw_reset_a: assert property (sw_reset_write |-> ##[1:4] rst_v == 8'hff)
    else $error("software reset did not assert resets");
  order_kept_a: assert property ((~rst_v & (~rst_v + 8'h01)) == 8'h00)
    else $error("reset release out of order");
  phy_lock_a: assert property ($fell(phy_reset_out) |-> $past(pll_locked_qualifier_in, 3))
    else $error("PHY released without lock");
  tx_ready_a: assert property ($fell(tx_cfg_reset_out) |-> $past(tx_ready_qualifier_in, 3))
    else $error("TX chain released without ready");
  rx_ready_a: assert property ($fell(rx_cfg_reset_out) |-> $past(rx_ready_qualifier_in, 3))
    else $error("RX chain released without ready");
  rd_answer_a: assert property (bus_rdvalid_out == $past(bus_read_in))
    else $error("read answer timing wrong");
  rd_idle_a: assert property (!bus_rdvalid_out |-> bus_rdata_out == 32'h0000_0000)
    else $error("read data not zero when idle");
  ctl_write_a: assert property (bus_write_in && bus_addr_in == 32'h0000_e014 |=> ##1
    fabric_control_out == ($past(bus_wdata_in, 2) & 32'h0000_0001)) else $error("control write");
  ctl_outside_a: assert property (bus_write_in && bus_addr_in[31:8] != 24'h00_00e0 |=> ##1
    $stable(fabric_control_out)) else $error("write outside window took effect");
  loop_mirror_a: assert property (rx_loopback_en_out == fabric_control_out[0])
    else $error("loopback differs from control bit");
endmodule
bind cssq_top cssq_top_monitor i_cssq_top_monitor (.mclk_in, .resetn_in,
  .hardware_reset_button_n_in, .pll_locked_qualifier_in, .tx_ready_qualifier_in,
  .rx_ready_qualifier_in, .bus_addr_in, .bus_write_in, .bus_read_in, .bus_wdata_in,
  .bus_rdata_out, .bus_rdvalid_out, .core_pll_reset_out, .phy_reset_out, .tx_cfg_reset_out,
  .tx_link_reset_out, .tx_frame_reset_out, .rx_cfg_reset_out, .rx_link_reset_out,
  .rx_frame_reset_out, .fabric_control_out, .rx_loopback_en_out);

// [testbench/cssq_cpu_model.sv]
/*
  Soft processor model: word reads and writes on the bridge port.
  Assumes one-cycle strobes and a registered read answer.
*/
`timescale 1ns/1ps
module cssq_cpu_model (
  input  wire logic        mclk_in,    // Clock
  input  wire logic [31:0] rdata_in,   // Read data
  input  wire logic        rdvalid_in, // Read answer
  output logic      [31:0] addr_out,   // Address
  output logic             write_out,  // Write strobe
  output logic             read_out,   // Read strobe
  output logic      [31:0] wdata_out   // Write data
);
  initial begin
    addr_out  = 32'h0000_0000;
    write_out = 1'b0;
    read_out  = 1'b0;
    wdata_out = 32'h0000_0000;
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_out  <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge mclk_in);
    write_out <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int n;
    n = 0;
    d = 32'hxxxx_xxxx;
    @(posedge mclk_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge mclk_in);
    read_out <= 1'b0;
    while (n < 4) begin
      @(posedge mclk_in);
      n++;
      if (rdvalid_in === 1'b1) begin
        d = rdata_in;
        n = 4;
      end
    end
    addr_out <= ~a;
  endtask
endmodule

// [testbench/cssq_top_test.sv]
/*
  Self-checking bench of cssq_top: release order, software reset, status and control.
  Assumes the processor model drives the bridge port.
*/
`timescale 1ns/1ps
module cssq_top_test;
  logic        mclk_in   = 1'b0;
  logic        resetn_in = 1'b0;
  logic        button_n  = 1'b1;
  logic        pll_q     = 1'b0;
  logic        tx_q      = 1'b0;
  logic        rx_q      = 1'b0;
  logic [1:0]  ltx       = 2'b00;
  logic [1:0]  lrx       = 2'b00;
  logic [1:0]  lerr      = 2'b00;
  logic [31:0] addr, wdata, rdata, fctl, rd_v;
  logic        wr_s, rd_s, rdv, loop;
  logic [7:0]  rst_v;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  initial forever #2.5 mclk_in = ~mclk_in;
  cssq_top #(.LINKS(2)) i_cssq_top (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .hardware_reset_button_n_in(button_n), .pll_locked_qualifier_in(pll_q),
    .tx_ready_qualifier_in(tx_q), .rx_ready_qualifier_in(rx_q), .link_tx_ready_in(ltx),
    .link_rx_ready_in(lrx), .link_chk_err_in(lerr), .bus_addr_in(addr), .bus_write_in(wr_s),
    .bus_read_in(rd_s), .bus_wdata_in(wdata), .bus_rdata_out(rdata), .bus_rdvalid_out(rdv),
    .core_pll_reset_out(rst_v[0]), .phy_reset_out(rst_v[1]), .tx_cfg_reset_out(rst_v[2]),
    .tx_link_reset_out(rst_v[3]), .tx_frame_reset_out(rst_v[4]), .rx_cfg_reset_out(rst_v[5]),
    .rx_link_reset_out(rst_v[6]), .rx_frame_reset_out(rst_v[7]), .fabric_control_out(fctl),
    .rx_loopback_en_out(loop));
  cssq_cpu_model i_cssq_cpu_model (.mclk_in(mclk_in), .rdata_in(rdata), .rdvalid_in(rdv),
    .addr_out(addr), .write_out(wr_s), .read_out(rd_s), .wdata_out(wdata));
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_rst(input logic [7:0] exp);
    check_word({24'h00_0000, rst_v}, {24'h00_0000, exp});
  endtask
  task automatic wait_rel(input int i);
    int n;
    n = 0;
    while (rst_v[i] !== 1'b0 && n < 200) begin
      @(posedge mclk_in);
      n++;
    end
    check_rst(8'hff << (i + 1));
  endtask
  task automatic hold_at(input logic [7:0] exp);
    repeat (40) @(posedge mclk_in);
    check_rst(exp);
  endtask
  task automatic t_reset_values;
    check_rst(8'hff);
    check_word(fctl, 32'h0000_0000);
    i_cssq_cpu_model.rd(32'h0000_e004, rd_v);
    check_word(rd_v, 32'h0000_00ff);
  endtask
  task automatic t_hw_order;
    wait_rel(0);
    hold_at(8'hfe);
    pll_q <= 1'b1;
    wait_rel(1);
    hold_at(8'hfc);
    tx_q <= 1'b1;
    for (int i = 2; i < 5; i++) wait_rel(i);
    hold_at(8'he0);
    rx_q <= 1'b1;
    for (int i = 5; i < 8; i++) wait_rel(i);
  endtask
  task automatic t_button;
    button_n <= 1'b0;
    repeat (10) @(posedge mclk_in);
    check_rst(8'hff);
    button_n <= 1'b1;
    for (int i = 0; i < 8; i++) wait_rel(i);
  endtask
  task automatic t_sw_manual;
    i_cssq_cpu_model.wr(32'h0000_e004, 32'h0000_00f8);
    i_cssq_cpu_model.wr(32'h0000_e000, 32'h0000_0003);
    repeat (4) @(posedge mclk_in);
    check_rst(8'hff);
    i_cssq_cpu_model.wr(32'h0000_e000, 32'h0000_0002);
    repeat (10) @(posedge mclk_in);
    check_rst(8'hf8);
    i_cssq_cpu_model.rd(32'h0000_e008, rd_v);
    check_word(rd_v & 32'h0100_00ff, 32'h0100_00f8);
    i_cssq_cpu_model.wr(32'h0000_e004, 32'h0000_0000);
    repeat (4) @(posedge mclk_in);
    check_rst(8'h00);
  endtask
  task automatic t_sw_builtin;
    i_cssq_cpu_model.wr(32'h0000_e000, 32'h0000_0001);
    repeat (4) @(posedge mclk_in);
    check_rst(8'hff);
    i_cssq_cpu_model.wr(32'h0000_e000, 32'h0000_0000);
    for (int i = 0; i < 8; i++) wait_rel(i);
  endtask
  task automatic t_control;
    i_cssq_cpu_model.wr(32'h0000_e014, 32'hffff_ffff);
    repeat (2) @(posedge mclk_in);
    check_word(fctl, 32'h0000_0001);
    check_word({31'h0000_0000, loop}, 32'h0000_0001);
    i_cssq_cpu_model.rd(32'h0000_e014, rd_v);
    check_word(rd_v, 32'h0000_0001);
    i_cssq_cpu_model.wr(32'h0000_e114, 32'h0000_0000);
    repeat (2) @(posedge mclk_in);
    check_word(fctl, 32'h0000_0001);
    i_cssq_cpu_model.wr(32'h0000_e014, 32'h0000_0000);
    repeat (2) @(posedge mclk_in);
    check_word(fctl, 32'h0000_0000);
  endtask
  task automatic t_status;
    ltx  <= 2'b10;
    lrx  <= 2'b01;
    lerr <= 2'b11;
    repeat (4) @(posedge mclk_in);
    i_cssq_cpu_model.rd(32'h0000_e010, rd_v);
    check_word(rd_v, 32'h0000_005d);
    pll_q <= 1'b0;
    ltx   <= 2'b01;
    lerr  <= 2'b00;
    repeat (4) @(posedge mclk_in);
    i_cssq_cpu_model.rd(32'h0000_e010, rd_v);
    check_word(rd_v, 32'h0000_0006);
    i_cssq_cpu_model.rd(32'h0000_e110, rd_v);
    check_word(rd_v, 32'h0000_0000);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset_values();
    t_hw_order();
    t_button();
    t_sw_manual();
    t_sw_builtin();
    t_control();
    t_status();
    tally_and_finish();
  end
endmodule
